// ==== hdl/epi_ext_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module epi_ext_detect
    import epi_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // synchronized pin and mode
    input  wire logic       pin_sync,
    input  wire logic [1:0] sense,
    // edge event and level state
    output logic            event_pulse,
    output logic            level_low
);
    logic prev_reg;
    logic prev_next;
    logic rise;
    logic fall;

    always_comb
    begin
        prev_next = clk_en ? pin_sync : prev_reg;
        rise = pin_sync & ~prev_reg;
        fall = ~pin_sync & prev_reg;
        case (epi_trig_e'(sense))
            EPI_TRIG_ANY:     event_pulse = rise | fall;
            EPI_TRIG_FALLING: event_pulse = fall;
            EPI_TRIG_RISING:  event_pulse = rise;
            default:          event_pulse = 1'b0;
        endcase
        level_low = (epi_trig_e'(sense) == EPI_TRIG_LOW) & ~pin_sync;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            prev_reg <= 1'b0;
        else
            prev_reg <= prev_next;
    end
endmodule
`default_nettype wire

// ==== hdl/epi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module epi_sync
    import epi_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage1_next;
    logic [W-1:0] stage2_next;

    always_comb
    begin
        stage1_next = clk_en ? async_in : stage1_reg;
        stage2_next = clk_en ? stage1_reg : sync_out;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end
        else
        begin
            stage1_reg <= stage1_next;
            sync_out   <= stage2_next;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/epi_top.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - unused upper register bits read zero, writes to them ignored
// - pin interrupt active only with global enable and its mask bit
// - pins synchronized first, edges found on the synchronized value
// - edge pulses give a request only if they span a clock edge with clk_en high
// - pin b sense at bits 3:2: low, any, falling, rising
// - pin a sense at bits 1:0 with identical coding
// - mask bit 1 enables pin b, bit 0 pin a, with global enable
// - pin activity counts even while the pin is an output
// - each external pin has its own request vector
// - qualifying edge event sets that pin's flag
// - flag, mask and global enable together raise the request
// - flag cleared when core enters the matching routine
// - writing one clears a flag, zero leaves it
// - flag held zero while pin is in low level mode
// - group enable bits 2,1,0 enable high, mid, low groups
// - any change on an enabled pin of enabled group requests
// - each pin change group has its own vector
// - per pin mask decides whether a pin contributes
// - low level wake taken from the raw pin, pin change wake from the synchronized pins
// - low level request stays while pin held low
module epi_top
    import epi_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // pins
    input  wire logic       ext_pin_a,
    input  wire logic       ext_pin_b,
    input  wire logic [7:0] change_pins_high,
    input  wire logic [6:0] change_pins_mid,
    input  wire logic [7:0] change_pins_low,
    // core side
    input  wire logic       global_irq_enable,
    input  wire epi_vec_s   vector_ack,
    output epi_vec_s        vector_req,
    // wake indication, registered on clk
    output logic            wake_req
);
    // pin synchronizers
    logic [1:0]  ext_sync;
    logic [22:0] chg_sync;
    logic [22:0] chg_prev_reg;
    logic [22:0] chg_prev_next;
    logic        gie_reg;
    logic        gie_next;

    // pins are sampled regardless of direction
    epi_sync #(.W(2)) u_ext_sync
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({ext_pin_b, ext_pin_a}),
        .sync_out (ext_sync)
    );

    epi_sync #(.W(23)) u_chg_sync
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({change_pins_high, change_pins_mid, change_pins_low}),
        .sync_out (chg_sync)
    );

    // registers
    logic [7:0] sense_reg;
    logic [7:0] sense_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] grp_en_reg;
    logic [7:0] grp_en_next;
    logic [7:0] ext_flags_reg;
    logic [7:0] ext_flags_next;
    logic [7:0] pc_flags_reg;
    logic [7:0] pc_flags_next;
    logic [7:0] pmask_lo_reg;
    logic [7:0] pmask_lo_next;
    logic [7:0] pmask_mid_reg;
    logic [7:0] pmask_mid_next;
    logic [7:0] pmask_hi_reg;
    logic [7:0] pmask_hi_next;
    logic [7:0] rdata_next;
    epi_vec_s   req_next;
    logic       wake_next;

    // edge detection on synchronized pins
    logic       ev_a;
    logic       ev_b;
    logic       lvl_a;
    logic       lvl_b;

    epi_ext_detect u_det_a
    (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .pin_sync    (ext_sync[0]),
        .sense       (sense_reg[EPI_SENSE_A_LSB +: 2]),
        .event_pulse (ev_a),
        .level_low   (lvl_a)
    );

    epi_ext_detect u_det_b
    (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .pin_sync    (ext_sync[1]),
        .sense       (sense_reg[EPI_SENSE_B_LSB +: 2]),
        .event_pulse (ev_b),
        .level_low   (lvl_b)
    );

    logic       wr_sense;
    logic       wr_mask;
    logic       wr_grp;
    logic       wr_eflag;
    logic       wr_pflag;
    logic       wr_plo;
    logic       wr_pmid;
    logic       wr_phi;
    logic [22:0] chg_event;
    logic [2:0] grp_event;
    logic       lvl_mode_a;
    logic       lvl_mode_b;

    always_comb
    begin
        wr_sense = reg_wr & (reg_addr == EPI_OFS_SENSE);
        wr_mask  = reg_wr & (reg_addr == EPI_OFS_MASK);
        wr_grp   = reg_wr & (reg_addr == EPI_OFS_GRP_EN);
        wr_eflag = reg_wr & (reg_addr == EPI_OFS_EXT_FLAGS);
        wr_pflag = reg_wr & (reg_addr == EPI_OFS_PC_FLAGS);
        wr_plo   = reg_wr & (reg_addr == EPI_OFS_PMASK_LO);
        wr_pmid  = reg_wr & (reg_addr == EPI_OFS_PMASK_MID);
        wr_phi   = reg_wr & (reg_addr == EPI_OFS_PMASK_HI);

        gie_next = global_irq_enable;
        chg_prev_next = chg_sync;

        chg_event = (chg_sync ^ chg_prev_reg)
                  & {pmask_hi_reg, pmask_mid_reg[6:0], pmask_lo_reg};
        grp_event[0] = |chg_event[7:0];
        grp_event[1] = |chg_event[14:8];
        grp_event[2] = |chg_event[22:15];

        lvl_mode_a = sense_reg[EPI_SENSE_A_LSB +: 2] == EPI_TRIG_LOW;
        lvl_mode_b = sense_reg[EPI_SENSE_B_LSB +: 2] == EPI_TRIG_LOW;

        sense_next = wr_sense ? (reg_wdata & EPI_SENSE_BITS) : sense_reg;
        mask_next  = wr_mask ? (reg_wdata & EPI_MASK_BITS) : mask_reg;
        grp_en_next = wr_grp ? (reg_wdata & EPI_GRP_BITS) : grp_en_reg;
        pmask_lo_next  = wr_plo ? reg_wdata : pmask_lo_reg;
        pmask_mid_next = wr_pmid ? (reg_wdata & EPI_PMASK_MID_BITS)
                                 : pmask_mid_reg;
        pmask_hi_next  = wr_phi ? reg_wdata : pmask_hi_reg;

        // external flags: clear by write one or ack, set wins
        ext_flags_next = ext_flags_reg;
        if (wr_eflag)
            ext_flags_next = ext_flags_next & ~(reg_wdata & EPI_MASK_BITS);
        if (vector_ack.ext_pin_a)
            ext_flags_next[0] = 1'b0;
        if (vector_ack.ext_pin_b)
            ext_flags_next[1] = 1'b0;
        if (ev_a)
            ext_flags_next[0] = 1'b1;
        if (ev_b)
            ext_flags_next[1] = 1'b1;
        if (lvl_mode_a)
            ext_flags_next[0] = 1'b0;
        if (lvl_mode_b)
            ext_flags_next[1] = 1'b0;

        // group flags
        pc_flags_next = pc_flags_reg;
        if (wr_pflag)
            pc_flags_next = pc_flags_next & ~(reg_wdata & EPI_GRP_BITS);
        if (vector_ack.vector_group_low)
            pc_flags_next[0] = 1'b0;
        if (vector_ack.vector_group_mid)
            pc_flags_next[1] = 1'b0;
        if (vector_ack.vector_group_high)
            pc_flags_next[2] = 1'b0;
        pc_flags_next[2:0] = pc_flags_next[2:0] | grp_event;

        // requests, one per vector
        req_next.ext_pin_a = gie_reg & mask_reg[0]
                           & (ext_flags_reg[0] | lvl_a);
        req_next.ext_pin_b = gie_reg & mask_reg[1]
                           & (ext_flags_reg[1] | lvl_b);
        req_next.vector_group_low  = gie_reg & grp_en_reg[0]
                                   & pc_flags_reg[0];
        req_next.vector_group_mid  = gie_reg & grp_en_reg[1]
                                   & pc_flags_reg[1];
        req_next.vector_group_high = gie_reg & grp_en_reg[2]
                                   & pc_flags_reg[2];
        // wake from raw pins in low level mode and from synchronized group changes, registered on clk
        wake_next = (mask_reg[0] & lvl_mode_a & ~ext_pin_a)
                  | (mask_reg[1] & lvl_mode_b & ~ext_pin_b)
                  | (|grp_event);

        case (reg_addr)
            EPI_OFS_SENSE:     rdata_next = sense_reg;
            EPI_OFS_MASK:      rdata_next = mask_reg;
            EPI_OFS_GRP_EN:    rdata_next = grp_en_reg;
            EPI_OFS_EXT_FLAGS: rdata_next = ext_flags_reg;
            EPI_OFS_PC_FLAGS:  rdata_next = pc_flags_reg;
            EPI_OFS_PMASK_LO:  rdata_next = pmask_lo_reg;
            EPI_OFS_PMASK_MID: rdata_next = pmask_mid_reg;
            EPI_OFS_PMASK_HI:  rdata_next = pmask_hi_reg;
            default:           rdata_next = EPI_RESET_VAL;
        endcase
        if (!reg_rd)
            rdata_next = EPI_RESET_VAL;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gie_reg       <= 1'b0;
            chg_prev_reg  <= '0;
            sense_reg     <= EPI_RESET_VAL;
            mask_reg      <= EPI_RESET_VAL;
            grp_en_reg    <= EPI_RESET_VAL;
            ext_flags_reg <= EPI_RESET_VAL;
            pc_flags_reg  <= EPI_RESET_VAL;
            pmask_lo_reg  <= EPI_RESET_VAL;
            pmask_mid_reg <= EPI_RESET_VAL;
            pmask_hi_reg  <= EPI_RESET_VAL;
            reg_rdata     <= EPI_RESET_VAL;
            vector_req    <= '0;
            wake_req      <= 1'b0;
        end
        else if (clk_en)
        begin
            gie_reg       <= gie_next;
            chg_prev_reg  <= chg_prev_next;
            sense_reg     <= sense_next;
            mask_reg      <= mask_next;
            grp_en_reg    <= grp_en_next;
            ext_flags_reg <= ext_flags_next;
            pc_flags_reg  <= pc_flags_next;
            pmask_lo_reg  <= pmask_lo_next;
            pmask_mid_reg <= pmask_mid_next;
            pmask_hi_reg  <= pmask_hi_next;
            reg_rdata     <= rdata_next;
            vector_req    <= req_next;
            wake_req      <= wake_next;
        end
    end
endmodule
`default_nettype wire

// ==== shared/epi_pkg.sv ====
`default_nettype none
package epi_pkg;
    // register offsets
    localparam logic [7:0] EPI_OFS_MASK      = 8'h3d;
    localparam logic [7:0] EPI_OFS_GRP_EN    = 8'h68;
    localparam logic [7:0] EPI_OFS_SENSE     = 8'h69;
    localparam logic [7:0] EPI_OFS_EXT_FLAGS = 8'h3c;
    localparam logic [7:0] EPI_OFS_PC_FLAGS  = 8'h3b;
    localparam logic [7:0] EPI_OFS_PMASK_LO  = 8'h6b;
    localparam logic [7:0] EPI_OFS_PMASK_MID = 8'h6c;
    localparam logic [7:0] EPI_OFS_PMASK_HI  = 8'h6d;
    // implemented bits per register
    localparam logic [7:0] EPI_SENSE_BITS    = 8'h0f;
    localparam logic [7:0] EPI_MASK_BITS     = 8'h03;
    localparam logic [7:0] EPI_GRP_BITS      = 8'h07;
    localparam logic [7:0] EPI_PMASK_MID_BITS = 8'h7f;
    // field positions
    localparam int EPI_SENSE_A_LSB = 0;
    localparam int EPI_SENSE_B_LSB = 2;
    // reset values
    localparam logic [7:0] EPI_RESET_VAL = 8'h00;
    // trigger coding
    typedef enum logic [1:0]
    {
        EPI_TRIG_LOW     = 2'h0,
        EPI_TRIG_ANY     = 2'h1,
        EPI_TRIG_FALLING = 2'h2,
        EPI_TRIG_RISING  = 2'h3
    } epi_trig_e;
    // requests and acknowledges toward the core, one bit per vector
    typedef struct packed
    {
        logic       vector_group_high;
        logic       vector_group_mid;
        logic       vector_group_low;
        logic       ext_pin_b;
        logic       ext_pin_a;
    } epi_vec_s;
endpackage
`default_nettype wire

// ==== testbench/epi_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epi_core_model
    import epi_pkg::*;
#(
    parameter int DLY = 3
)
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     sys_rst,
    // bench control
    input  wire logic     ack_en,
    // interrupt lines
    input  wire epi_vec_s vector_req,
    output epi_vec_s      vector_ack
);
    logic [4:0] req;
    int         wait_cnt;

    assign req = vector_req;
    // enter the lowest pending vector after a latency
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vector_ack <= '0;
            wait_cnt   <= 0;
        end
        else if (ack_en && req != 5'h00 && wait_cnt >= DLY)
        begin
            vector_ack <= epi_vec_s'(req & (~req + 5'h01));
            wait_cnt   <= 0;
        end
        else
        begin
            vector_ack <= '0;
            wait_cnt   <= (ack_en && req != 5'h00) ? wait_cnt + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/epi_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module epi_top_sva
    import epi_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pin and core
    input wire logic       ext_pin_a,
    input wire logic       global_irq_enable,
    input wire epi_vec_s   vector_req
);
    logic [7:0] sense_reg;
    logic [7:0] sense_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] grp_reg;
    logic [7:0] grp_next;
    logic [7:0] raddr_reg;
    logic [7:0] unused;
    logic       lvl_a;
    logic       lvl_mode_a;
    logic       rise_a_ok;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // shadow copies of the control registers
    always_comb
    begin
        sense_next = (reg_wr && reg_addr == EPI_OFS_SENSE) ? reg_wdata : sense_reg;
        mask_next  = (reg_wr && reg_addr == EPI_OFS_MASK) ? reg_wdata : mask_reg;
        grp_next   = (reg_wr && reg_addr == EPI_OFS_GRP_EN) ? reg_wdata : grp_reg;
        case (raddr_reg)
            EPI_OFS_SENSE:     unused = ~EPI_SENSE_BITS;
            EPI_OFS_MASK:      unused = ~EPI_MASK_BITS;
            EPI_OFS_GRP_EN:    unused = ~EPI_GRP_BITS;
            EPI_OFS_EXT_FLAGS: unused = 8'hfc;
            EPI_OFS_PC_FLAGS:  unused = 8'hf8;
            EPI_OFS_PMASK_MID: unused = ~EPI_PMASK_MID_BITS;
            EPI_OFS_PMASK_LO,
            EPI_OFS_PMASK_HI:  unused = 8'h00;
            default:           unused = 8'hff;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sense_reg <= 8'h00;
            mask_reg  <= 8'h00;
            grp_reg   <= 8'h00;
            raddr_reg <= 8'h00;
        end
        else
        begin
            sense_reg <= sense_next;
            mask_reg  <= mask_next;
            grp_reg   <= grp_next;
            raddr_reg <= reg_addr;
        end
    end

    assign lvl_mode_a = sense_reg[1:0] == 2'h0;
    assign lvl_a      = !ext_pin_a && lvl_mode_a && mask_reg[0] && global_irq_enable;
    assign rise_a_ok  = sense_reg[1:0] == EPI_TRIG_RISING && mask_reg[0] && global_irq_enable;

    sequence s_wr_sense;
        reg_wr && reg_addr == EPI_OFS_SENSE;
    endsequence
    sequence s_rd_sense;
        reg_rd && !reg_wr && reg_addr == EPI_OFS_SENSE;
    endsequence
    property p_sense_back;
        logic [7:0] v;
        (s_wr_sense, v = reg_wdata) ##1 !reg_wr ##1 s_rd_sense
            |=> reg_rdata == (v & EPI_SENSE_BITS);
    endproperty

    AST_SENSE_BACK: assert property (p_sense_back)
        else $error("sense field readback differs");
    AST_UNUSED_ZERO: assert property ($past(reg_rd) |-> (reg_rdata & unused) == 8'h00)
        else $error("unused read bits not zero");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    AST_GIE_GATE: assert property (!global_irq_enable [*3] |=> vector_req == 5'h00)
        else $error("request without global enable");
    AST_MASK_GATE: assert property (!mask_reg[0] [*3] |=> !vector_req.ext_pin_a)
        else $error("pin a request while masked");
    AST_GROUP_GATE: assert property (!grp_reg[0] [*3] |=> !vector_req.vector_group_low)
        else $error("low group request while disabled");
    AST_LEVEL_HOLD: assert property (lvl_a [*5] |-> vector_req.ext_pin_a)
        else $error("level request missing while pin low");
    AST_FLAG_LEVEL: assert property ($past(reg_rd) && raddr_reg == EPI_OFS_EXT_FLAGS
        && $past(lvl_mode_a) |-> !reg_rdata[0])
        else $error("pin a flag set in level mode");
    AST_EDGE_REQ: assert property (rise_a_ok && $rose(ext_pin_a) ##1 ext_pin_a
        |-> ##[1:5] vector_req.ext_pin_a)
        else $error("rising edge gave no request");
endmodule

bind epi_top epi_top_sva i_epi_top_sva (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_a(ext_pin_a),
    .global_irq_enable(global_irq_enable), .vector_req(vector_req));
`default_nettype wire

// ==== testbench/tb_epi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_epi_top;
    import epi_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        pin_a = 1'b1;
    logic        pin_b = 1'b1;
    logic [22:0] chg = '0;
    logic        gie = 1'b0;
    logic        ack_en = 1'b0;
    epi_vec_s    vreq;
    epi_vec_s    vack;
    logic        wake;
    logic [4:0]  ev;
    logic [7:0]  pm;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          mdl [256];
    int          k;
    int          w;
    int          b;
    logic [7:0]  addrs [9] = '{EPI_OFS_SENSE, EPI_OFS_MASK, EPI_OFS_GRP_EN,
        EPI_OFS_EXT_FLAGS, EPI_OFS_PC_FLAGS, EPI_OFS_PMASK_LO,
        EPI_OFS_PMASK_MID, EPI_OFS_PMASK_HI, 8'h00};

    epi_top i_epi_top (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_a(pin_a),
        .ext_pin_b(pin_b), .change_pins_high(chg[22:15]),
        .change_pins_mid(chg[14:8]), .change_pins_low(chg[7:0]),
        .global_irq_enable(gie), .vector_ack(vack), .vector_req(vreq),
        .wake_req(wake));
    epi_core_model i_epi_core_model (.clk(clk), .sys_rst(sys_rst),
        .ack_en(ack_en), .vector_req(vreq), .vector_ack(vack));

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] bits(input logic [7:0] a);
        case (a)
            EPI_OFS_SENSE:     return EPI_SENSE_BITS;
            EPI_OFS_MASK:      return EPI_MASK_BITS;
            EPI_OFS_GRP_EN:    return EPI_GRP_BITS;
            EPI_OFS_PMASK_MID: return EPI_PMASK_MID_BITS;
            EPI_OFS_PMASK_LO,
            EPI_OFS_PMASK_HI:  return 8'hff;
            default:           return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        if (a == EPI_OFS_EXT_FLAGS || a == EPI_OFS_PC_FLAGS)
            mdl[a] = mdl[a] & ~int'(d);
        else
            mdl[a] = int'(d & bits(a));
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, 8'(mdl[a]));
        @(posedge clk);
    endtask

    task automatic req_is(input logic [4:0] e);
        #1;
        chk({3'h0, vreq}, {3'h0, e});
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic ack_run();
        ack_en <= 1'b1;
        cyc(8);
        ack_en <= 1'b0;
    endtask

    initial
    begin
        void'($urandom(46));
        cyc(10);
        sys_rst <= 1'b0;
        cyc(1);
        foreach (addrs[i]) rd(addrs[i]);
        repeat (2) foreach (addrs[i])
        begin
            wr(addrs[i], 8'($urandom));
            rd(addrs[i]);
        end
        gie <= 1'b1;
        for (int p = 0; p < 2; p++)
            for (int m = 1; m < 4; m++)
            begin
                wr(EPI_OFS_SENSE, 8'(m << (2 * p)));
                wr(EPI_OFS_MASK, 8'(1 << p));
                wr(EPI_OFS_EXT_FLAGS, 8'h03);
                if (p == 0) pin_a <= 1'b0; else pin_b <= 1'b0;
                cyc(6);
                ev = (m != 3) ? 5'(1 << p) : 5'h00;
                mdl[EPI_OFS_EXT_FLAGS] = int'(ev);
                req_is(ev);
                rd(EPI_OFS_EXT_FLAGS);
                wr(EPI_OFS_EXT_FLAGS, 8'h00);
                rd(EPI_OFS_EXT_FLAGS);
                wr(EPI_OFS_EXT_FLAGS, 8'h03);
                cyc(2);
                req_is(5'h00);
                if (p == 0) pin_a <= 1'b1; else pin_b <= 1'b1;
                cyc(6);
                req_is((m != 2) ? 5'(1 << p) : 5'h00);
                ack_run();
                mdl[EPI_OFS_EXT_FLAGS] = 0;
                req_is(5'h00);
                rd(EPI_OFS_EXT_FLAGS);
            end
        wr(EPI_OFS_SENSE, 8'h00);
        wr(EPI_OFS_MASK, 8'h01);
        pin_a <= 1'b0;
        cyc(6);
        req_is(5'h01);
        chk({7'h0, wake}, 8'h01);
        rd(EPI_OFS_EXT_FLAGS);
        gie <= 1'b0;
        cyc(4);
        req_is(5'h00);
        gie <= 1'b1;
        cyc(4);
        req_is(5'h01);
        pin_a <= 1'b1;
        cyc(6);
        req_is(5'h00);
        for (int g = 0; g < 3; g++)
        begin
            w = (g == 1) ? 7 : 8;
            b = (g == 2) ? 15 : g * 8;
            k = $urandom_range(w - 1);
            pm = 8'($urandom) | 8'(1 << k);
            pm[(k + 1) % w] = 1'b0;
            wr(EPI_OFS_GRP_EN, 8'(1 << g));
            wr(8'(EPI_OFS_PMASK_LO + g), pm);
            wr(EPI_OFS_PC_FLAGS, 8'h07);
            chg[b + (k + 1) % w] <= ~chg[b + (k + 1) % w];
            cyc(6);
            req_is(5'h00);
            chg[b + k] <= ~chg[b + k];
            cyc(6);
            mdl[EPI_OFS_PC_FLAGS] = 1 << g;
            req_is(5'(1 << (2 + g)));
            rd(EPI_OFS_PC_FLAGS);
            wr(EPI_OFS_PC_FLAGS, 8'(1 << g));
            cyc(2);
            req_is(5'h00);
            chg[b + k] <= ~chg[b + k];
            cyc(6);
            ack_run();
            mdl[EPI_OFS_PC_FLAGS] = 0;
            req_is(5'h00);
            rd(EPI_OFS_PC_FLAGS);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
